// File: core/hbc_params.svh
`ifndef HBC_PARAMS_SVH
`define HBC_PARAMS_SVH
// Behaviour
// - regulation reporting set: regulation events drive fault pin and global fault bit
// - thermal policy 0 latches overtemperature fault, 1 recovers when condition ends
// - warning reporting set: thermal warning drives fault pin and global fault bit
// - charge-pump undervoltage disable set suppresses that fault completely
// - retry field picks wait 0.5, 1, 2 or 4 ms; resets to 11
// - overcurrent policy: latched, auto retry, report only, or ignore
// - host writes 1 to fault clear; device clears latched overtemperature and overcurrent bits
// - fault clear bit drops to 0 by itself, never reads back 1
// - lock code 011 freezes first control register; lock and clear stay writable
// - lock code 100 unlocks; it is also the reset value
// - independent mode: output one disable puts half bridge 1 in high impedance
// - independent mode: output two disable puts half bridge 2 in high impedance
// - serial control selected: input one bit replaces first logic pin
// - serial control selected: input two bit replaces second logic pin
// - standby open-load start runs diagnostic, bit returns to 0 when complete
// - open-load delay bit selects 300 us or 1.2 ms
// - active open-load enable bit turns active-mode diagnostics on, reset off
// - trip level field selects 4, 5.4, 6.5 or 7 A; resets to 10
// - regulation disable field gates regulation per output
// - input-source bit: 0 follows logic pins, 1 follows serial input bits
// - read-only global fault bit mirrors the fault pin
// - mode field: phase/enable, PWM, independent, or inputs off with high impedance
`define HBC_ADDR_FAULT 6'h00
`define HBC_ADDR_DIAG 6'h01
`define HBC_ADDR_IC1 6'h02
`define HBC_ADDR_IC2 6'h03
`define HBC_ADDR_IC3 6'h04
`define HBC_ADDR_IC4 6'h05
`define HBC_IC1_RESET 8'h50
`define HBC_IC2_RESET 8'h0C
`define HBC_IC3_RESET 8'h40
`define HBC_IC4_RESET 8'h08
`define HBC_IC1_SPI_IN 5
`define HBC_IC2_REG_REP 7
`define HBC_IC2_TSD_POL 6
`define HBC_IC2_WARN_REP 5
`define HBC_IC2_CPUV_DIS 4
`define HBC_IC3_CLR 7
`define HBC_IC3_HB1_OFF 3
`define HBC_IC3_HB2_OFF 2
`define HBC_IC3_IN1 1
`define HBC_IC3_IN2 0
`define HBC_IC4_OLP_START 6
`define HBC_IC4_OLP_LONG 5
`define HBC_IC4_OLA_EN 4
`define HBC_LOCK_CODE 3'h3
`define HBC_UNLOCK_CODE 3'h4
`define HBC_CLK_PERIOD_NS 10
`define HBC_OCP_RETRY_MIN_MS 0.5
`define HBC_OLP_SHORT_US 300
`define HBC_OLP_LONG_MS 1.2
`define HBC_TMR_W 20
`endif

// File: core/hbc_pkg.sv
package hbc_pkg;
    typedef enum logic [1:0] {
        HBC_MODE_PH_EN = 2'h0,
        HBC_MODE_PWM   = 2'h1,
        HBC_MODE_INDEP = 2'h2,
        HBC_MODE_OFF   = 2'h3
    } hbc_mode_t;
    typedef enum logic [1:0] {
        HBC_OCP_LATCH  = 2'h0,
        HBC_OCP_RETRY  = 2'h1,
        HBC_OCP_REPORT = 2'h2,
        HBC_OCP_IGNORE = 2'h3
    } hbc_ocp_t;
    typedef enum logic [1:0] {
        HBC_OLP_IDLE = 2'h0,
        HBC_OLP_WAIT = 2'h1,
        HBC_OLP_DONE = 2'h3
    } hbc_olp_state_t;
    typedef struct packed {
        hbc_olp_state_t  state;
        logic [19:0]     cnt;
    } hbc_olp_st_t;
    typedef struct packed {
        logic [7:0]  ic1;
        logic [7:0]  ic2;
        logic [7:0]  ic3;
        logic [7:0]  ic4;
        logic        tsd;
        logic        ocp;
        logic        cpuv;
        logic        warn;
        logic [1:0]  reg_evt;
        logic [19:0] retry_cnt;
        logic [1:0]  pin_meta;
        logic [1:0]  pin_sync;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        fault_n;
        logic        drv1;
        logic        drv2;
        logic        hiz1;
        logic        hiz2;
        logic        olp_start;
    } hbc_st_t;
endpackage

// File: core/hbc_olp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hbc_olp_if;
    logic start;
    logic long_dly;
    logic busy;
    logic done;
    modport ctl (output start, output long_dly, input busy, input done);
    modport tmr (input start, input long_dly, output busy, output done);
endinterface
`default_nettype wire

// File: core/hbc_olp.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbc_params.svh"
module hbc_olp #(
    parameter int SHORT_CYC = 30000,
    parameter int LONG_CYC  = 120000
) (
    input  wire logic clk,
    input  wire logic srst,
    hbc_olp_if.tmr    olp
);
    initial begin
        if (SHORT_CYC < 1 || LONG_CYC >= (1 << `HBC_TMR_W) || SHORT_CYC >= (1 << `HBC_TMR_W))
            $error("open-load delay out of range");
    end
    hbc_pkg::hbc_olp_st_t st_reg;
    hbc_pkg::hbc_olp_st_t st_next;
    always_comb begin
        st_next = st_reg;
        unique case (st_reg.state)
            hbc_pkg::HBC_OLP_IDLE: begin
                if (olp.start) begin
                    st_next.state = hbc_pkg::HBC_OLP_WAIT;
                    // delay by selection
                    st_next.cnt = olp.long_dly ? 20'(LONG_CYC - 1) : 20'(SHORT_CYC - 1);
                end
            end
            hbc_pkg::HBC_OLP_WAIT: begin
                if (st_reg.cnt == 20'h0) begin
                    st_next.state = hbc_pkg::HBC_OLP_DONE;
                end else begin
                    st_next.cnt = st_reg.cnt - 20'h1;
                end
            end
            hbc_pkg::HBC_OLP_DONE: st_next.state = hbc_pkg::HBC_OLP_IDLE;
            default: st_next.state = hbc_pkg::HBC_OLP_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign olp.busy = st_reg.state == hbc_pkg::HBC_OLP_WAIT;
    assign olp.done = st_reg.state == hbc_pkg::HBC_OLP_DONE;
endmodule
`default_nettype wire

// File: core/hbc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbc_params.svh"
module hbc_regs #(
    parameter int RETRY_BASE_CYC = int'(`HBC_OCP_RETRY_MIN_MS * 1.0e6 / `HBC_CLK_PERIOD_NS),
    parameter int OLP_SHORT_CYC  = int'(`HBC_OLP_SHORT_US * 1.0e3 / `HBC_CLK_PERIOD_NS),
    parameter int OLP_LONG_CYC   = int'(`HBC_OLP_LONG_MS * 1.0e6 / `HBC_CLK_PERIOD_NS)
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       in1_pin,
    input  wire logic       in2_pin,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       overtemp,
    input  wire logic       thermal_warning,
    input  wire logic       cpuv_detect,
    input  wire logic       overcurrent,
    input  wire logic [1:0] current_regulation_event,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,
    output logic            fault_output_pin_n,
    output logic            bridge_in1,
    output logic            bridge_in2,
    output logic            output_one_hiz,
    output logic            output_two_hiz,
    output logic [1:0]      bridge_mode,
    output logic [1:0]      regulation_trip_level,
    output logic [1:0]      regulation_disable,
    output logic            active_open_load_enable,
    output logic            open_load_running
);
    initial begin
        if (RETRY_BASE_CYC < 1 || RETRY_BASE_CYC * 8 >= (1 << `HBC_TMR_W))
            $error("retry base out of range");
    end

    hbc_pkg::hbc_st_t st_reg;
    hbc_pkg::hbc_st_t st_next;
    hbc_olp_if        olp ();

    hbc_olp #(
        .SHORT_CYC (OLP_SHORT_CYC),
        .LONG_CYC  (OLP_LONG_CYC)
    ) u_olp (
        .clk  (clk),
        .srst (srst),
        .olp  (olp.tmr)
    );

    function automatic logic [19:0] retry_cycles(input logic [1:0] code);
        retry_cycles = 20'(RETRY_BASE_CYC << code);
    endfunction

    function automatic logic hit(input logic [5:0] a);
        hit = reg_addr == a;
    endfunction

    logic wr_ic3;
    logic clr;
    logic locked;
    logic ocp_act;
    logic [1:0] ocp_pol;
    logic [2:0] lock_code;
    logic [1:0] src;
    logic fault_any;
    hbc_pkg::hbc_mode_t mode;

    assign olp.start    = st_reg.olp_start;
    assign olp.long_dly = st_reg.ic4[`HBC_IC4_OLP_LONG];

    always_comb begin
        st_next   = st_reg;
        wr_ic3    = reg_wr && hit(`HBC_ADDR_IC3);
        clr       = wr_ic3 && reg_wdata[`HBC_IC3_CLR];
        locked    = st_reg.ic3[6:4] == `HBC_LOCK_CODE;
        ocp_pol   = st_reg.ic2[1:0];
        lock_code = reg_wdata[6:4];
        mode      = hbc_pkg::hbc_mode_t'(st_reg.ic1[1:0]);
        // input pins, two-flop sync
        st_next.pin_meta = {in1_pin, in2_pin};
        st_next.pin_sync = st_reg.pin_meta;
        // register writes
        if (reg_wr && hit(`HBC_ADDR_IC1) && !locked) begin
            st_next.ic1 = reg_wdata;
        end
        if (reg_wr && hit(`HBC_ADDR_IC2)) begin
            st_next.ic2 = reg_wdata;
        end
        if (wr_ic3) begin
            st_next.ic3[3:0] = reg_wdata[3:0];
            if (lock_code == `HBC_LOCK_CODE || lock_code == `HBC_UNLOCK_CODE) begin
                st_next.ic3[6:4] = lock_code;
            end
        end
        st_next.ic3[`HBC_IC3_CLR] = 1'b0;
        st_next.olp_start = 1'b0;
        if (reg_wr && hit(`HBC_ADDR_IC4)) begin
            st_next.ic4 = reg_wdata;
            // a running diagnostic keeps its start bit
            st_next.ic4[`HBC_IC4_OLP_START] = st_reg.ic4[`HBC_IC4_OLP_START]
                || reg_wdata[`HBC_IC4_OLP_START];
            st_next.olp_start = reg_wdata[`HBC_IC4_OLP_START] && !st_reg.ic4[`HBC_IC4_OLP_START];
        end
        if (olp.done) begin
            st_next.ic4[`HBC_IC4_OLP_START] = 1'b0;
        end
        // overtemperature
        if (st_reg.ic2[`HBC_IC2_TSD_POL]) begin
            st_next.tsd = overtemp;
        end else begin
            st_next.tsd = overtemp || (st_reg.tsd && !clr);
        end
        st_next.cpuv  = cpuv_detect && !st_reg.ic2[`HBC_IC2_CPUV_DIS];
        st_next.warn    = thermal_warning;
        // disable bit 0 gates output one, event bit 1 is output one
        st_next.reg_evt = current_regulation_event & ~{st_reg.ic4[0], st_reg.ic4[1]};
        // overcurrent
        if (st_reg.retry_cnt != 20'h0) begin
            st_next.retry_cnt = st_reg.retry_cnt - 20'h1;
        end
        if (overcurrent && ocp_pol != hbc_pkg::HBC_OCP_IGNORE) begin
            st_next.ocp = 1'b1;
            if (ocp_pol == hbc_pkg::HBC_OCP_RETRY) begin
                st_next.retry_cnt = retry_cycles(st_reg.ic2[3:2]);
            end
        end else if (clr || ocp_pol == hbc_pkg::HBC_OCP_IGNORE) begin
            st_next.ocp = 1'b0;
            st_next.retry_cnt = 20'h0;
        end else if (ocp_pol == hbc_pkg::HBC_OCP_RETRY && st_reg.ocp && st_reg.retry_cnt == 20'h1) begin
            st_next.ocp = 1'b0;
        end
        ocp_act = st_next.ocp && (ocp_pol == hbc_pkg::HBC_OCP_LATCH || ocp_pol == hbc_pkg::HBC_OCP_RETRY);
        fault_any = st_next.tsd || st_next.ocp || st_next.cpuv
            || (st_next.warn && st_next.ic2[`HBC_IC2_WARN_REP])
            || ((|st_next.reg_evt) && st_next.ic2[`HBC_IC2_REG_REP]);
        st_next.fault_n = !fault_any;
        // bridge control
        src = st_reg.ic1[`HBC_IC1_SPI_IN] ? st_reg.ic3[1:0] : st_reg.pin_sync;
        st_next.drv1 = src[1];
        st_next.drv2 = src[0];
        st_next.hiz1 = mode == hbc_pkg::HBC_MODE_OFF
            || (mode == hbc_pkg::HBC_MODE_INDEP && st_reg.ic3[`HBC_IC3_HB1_OFF])
            || st_next.tsd || ocp_act || st_next.cpuv;
        st_next.hiz2 = mode == hbc_pkg::HBC_MODE_OFF
            || (mode == hbc_pkg::HBC_MODE_INDEP && st_reg.ic3[`HBC_IC3_HB2_OFF])
            || st_next.tsd || ocp_act || st_next.cpuv;
        // read port
        st_next.rvalid = reg_rd;
        st_next.rdata  = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `HBC_ADDR_FAULT: st_next.rdata = {1'b0, !st_reg.fault_n, st_reg.warn, 1'b0,
                                                  st_reg.cpuv, st_reg.ocp, st_reg.tsd, 1'b0};
                `HBC_ADDR_DIAG:  st_next.rdata = {2'h0, st_reg.reg_evt, 4'h0};
                `HBC_ADDR_IC1:   st_next.rdata = st_reg.ic1;
                `HBC_ADDR_IC2:   st_next.rdata = st_reg.ic2;
                `HBC_ADDR_IC3:   st_next.rdata = st_reg.ic3;
                `HBC_ADDR_IC4:   st_next.rdata = st_reg.ic4;
                default:         st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg         <= '0;
            st_reg.ic1     <= `HBC_IC1_RESET;
            st_reg.ic2     <= `HBC_IC2_RESET;
            st_reg.ic3     <= `HBC_IC3_RESET;
            st_reg.ic4     <= `HBC_IC4_RESET;
            st_reg.fault_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata               = st_reg.rdata;
    assign reg_rvalid              = st_reg.rvalid;
    assign fault_output_pin_n      = st_reg.fault_n;
    assign bridge_in1              = st_reg.drv1;
    assign bridge_in2              = st_reg.drv2;
    assign output_one_hiz          = st_reg.hiz1;
    assign output_two_hiz          = st_reg.hiz2;
    assign bridge_mode             = st_reg.ic1[1:0];
    assign regulation_trip_level   = st_reg.ic4[3:2];
    assign regulation_disable      = st_reg.ic4[1:0];
    assign active_open_load_enable = st_reg.ic4[`HBC_IC4_OLA_EN];
    assign open_load_running       = st_reg.ic4[`HBC_IC4_OLP_START];

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_reg_report;
        st_reg.ic2[7] && (|st_reg.reg_evt) |-> !fault_output_pin_n;
    endproperty
    a_reg_report: assert property (p_reg_report) else $error("regulation not reported");

    property p_tsd_auto;
        st_reg.ic2[6] && !overtemp ##1 st_reg.ic2[6] |-> !st_reg.tsd;
    endproperty
    a_tsd_auto: assert property (p_tsd_auto) else $error("auto thermal fault stuck");

    property p_tsd_latch;
        !st_reg.ic2[6] && overtemp |=> st_reg.tsd && !fault_output_pin_n;
    endproperty
    a_tsd_latch: assert property (p_tsd_latch) else $error("thermal fault not latched");

    property p_cpuv_off;
        st_reg.ic2[4] |=> !st_reg.cpuv;
    endproperty
    a_cpuv_off: assert property (p_cpuv_off) else $error("cpuv not suppressed");

    property p_clear;
        clr && !overcurrent && !overtemp |=> !st_reg.ocp && !st_reg.tsd;
    endproperty
    a_clear: assert property (p_clear) else $error("fault clear ignored");

    property p_clr_reads_zero;
        reg_rd && reg_addr == `HBC_ADDR_IC3 |=> reg_rvalid && !reg_rdata[7];
    endproperty
    a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("clear bit read as one");

    property p_lock_freeze;
        locked && reg_wr && reg_addr == `HBC_ADDR_IC1 |=> $stable(st_reg.ic1);
    endproperty
    a_lock_freeze: assert property (p_lock_freeze) else $error("locked register changed");

    property p_unlock;
        wr_ic3 && reg_wdata[6:4] == `HBC_UNLOCK_CODE |=> st_reg.ic3[6:4] == `HBC_UNLOCK_CODE;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock failed");

    property p_output_one_hiz;
        st_reg.ic1[1:0] == 2'h2 && st_reg.ic3[3] |=> output_one_hiz;
    endproperty
    a_output_one_hiz: assert property (p_output_one_hiz) else $error("half bridge 1 not off");

    property p_serial_src;
        st_reg.ic1[5] |=> bridge_in1 == $past(st_reg.ic3[1]) && bridge_in2 == $past(st_reg.ic3[0]);
    endproperty
    a_serial_src: assert property (p_serial_src) else $error("serial inputs not used");

    property p_olp_done;
        olp.done |=> !st_reg.ic4[6];
    endproperty
    a_olp_done: assert property (p_olp_done) else $error("open-load start stuck");

    c_lock: cover property (wr_ic3 && reg_wdata[6:4] == `HBC_LOCK_CODE);
    c_olp_done: cover property (olp.done);
    c_retry_end: cover property (st_reg.ocp && st_reg.ic2[1:0] == 2'h1 ##1 !st_reg.ocp);
endmodule
`default_nettype wire

// File: testbench/hbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module hbc_host (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [5:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 6'h3F;
        reg_wdata = 8'h00;
    end
    // one write; lines inverted once released
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // one read, answer awaited under a bound
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// File: testbench/hbc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hbc_regs_tb;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       in1_pin = 1'b0;
    logic       in2_pin = 1'b0;
    logic       ot = 1'b0;
    logic       tw = 1'b0;
    logic       cp = 1'b0;
    logic       oc = 1'b0;
    logic [1:0] rg = 2'h0;
    logic       reg_wr, reg_rd, reg_rvalid, pin_n, b1, b2, hz1, hz2, ola, olr;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] mode, trip, rdis;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    always #5 clk = ~clk;
    hbc_regs #(.RETRY_BASE_CYC(4), .OLP_SHORT_CYC(5), .OLP_LONG_CYC(9)) u_hbc_regs (
        .clk(clk), .srst(srst), .in1_pin(in1_pin), .in2_pin(in2_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .overtemp(ot), .thermal_warning(tw), .cpuv_detect(cp),
        .overcurrent(oc), .current_regulation_event(rg), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .fault_output_pin_n(pin_n), .bridge_in1(b1), .bridge_in2(b2), .output_one_hiz(hz1),
        .output_two_hiz(hz2), .bridge_mode(mode), .regulation_trip_level(trip), .regulation_disable(rdis),
        .active_open_load_enable(ola), .open_load_running(olr));
    hbc_host u_hbc_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic summarize;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_hbc_host.wr(a, d);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        u_hbc_host.rd(a, d, ok);
        if (!ok) begin
            n_mismatch++;
            $display("MISMATCH read_answer expected 01 seen 00");
            summarize();
        end else begin
            cmp($sformatf("reg_%h", a), e, d);
        end
    endtask
    task automatic setc(input logic [5:0] v);
        @(negedge clk);
        {ot, tw, cp, oc, rg} = v;
        cyc(3);
    endtask
    task automatic pin(input logic e);
        cmp("fault_pin", {7'h0, e}, {7'h0, pin_n});
    endtask
    task automatic outs(input logic [3:0] e);
        cyc(4);
        cmp("bridge_outs", {4'h0, e}, {4'h0, hz1, hz2, b1, b2});
    endtask
    task automatic t_reset;
        rchk(6'h02, 8'h50);
        rchk(6'h03, 8'h0C);
        rchk(6'h04, 8'h40);
        rchk(6'h05, 8'h08);
        pin(1'b1);
        wr(6'h03, 8'hA5);
        wr(6'h3F, 8'hFF);
        rchk(6'h03, 8'hA5);
        wr(6'h03, 8'h0C);
    endtask
    task automatic t_lock;
        wr(6'h04, 8'h30);
        wr(6'h02, 8'hFF);
        rchk(6'h02, 8'h50);
        wr(6'h04, 8'h70);
        wr(6'h02, 8'h21);
        rchk(6'h04, 8'h30);
        rchk(6'h02, 8'h50);
        wr(6'h04, 8'hC0);
        rchk(6'h04, 8'h40);
        wr(6'h02, 8'h21);
        rchk(6'h02, 8'h21);
        wr(6'h02, 8'h50);
    endtask
    task automatic t_faults;
        setc(6'h04);
        setc(6'h00);
        pin(1'b0);
        cmp("hiz_one", 8'h01, {7'h0, hz1});
        rchk(6'h00, 8'h44);
        wr(6'h04, 8'hC0);
        cyc(2);
        pin(1'b1);
        rchk(6'h00, 8'h00);
        setc(6'h10);
        pin(1'b1);
        wr(6'h03, 8'h2C);
        cyc(2);
        pin(1'b0);
        setc(6'h00);
        wr(6'h03, 8'h0C);
        wr(6'h04, 8'hC0);
        setc(6'h03);
        pin(1'b1);
        wr(6'h03, 8'h8C);
        cyc(2);
        pin(1'b0);
        rchk(6'h01, 8'h30);
        wr(6'h05, 8'h09);
        rchk(6'h01, 8'h10);
        setc(6'h00);
        wr(6'h03, 8'h0C);
        wr(6'h05, 8'h08);
        wr(6'h04, 8'hC0);
        setc(6'h20);
        setc(6'h00);
        pin(1'b0);
        wr(6'h04, 8'hC0);
        wr(6'h03, 8'h4C);
        setc(6'h20);
        pin(1'b0);
        setc(6'h00);
        pin(1'b1);
        wr(6'h03, 8'h1C);
        setc(6'h08);
        pin(1'b1);
        wr(6'h03, 8'h0C);
        cyc(3);
        pin(1'b0);
        setc(6'h00);
        wr(6'h04, 8'hC0);
        cyc(2);
        pin(1'b1);
    endtask
    task automatic t_ocp;
        int n;
        wr(6'h03, 8'h05);
        setc(6'h04);
        cmp("hiz_one", 8'h01, {7'h0, hz1});
        @(negedge clk);
        oc = 1'b0;
        n = 0;
        while (hz1 === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        cmp("retry_ok", 8'h01, {7'h0, n >= 6 && n <= 11});
        pin(1'b1);
        wr(6'h03, 8'h0E);
        setc(6'h04);
        setc(6'h00);
        cmp("hiz_report", 8'h00, {7'h0, hz1});
        pin(1'b0);
        wr(6'h04, 8'hC0);
        wr(6'h03, 8'h0F);
        setc(6'h04);
        pin(1'b1);
        setc(6'h00);
        wr(6'h03, 8'h0C);
    endtask
    task automatic t_bridge;
        wr(6'h02, 8'h72);
        wr(6'h04, 8'h4B);
        outs(4'hB);
        cmp("bridge_mode", 8'h02, {6'h0, mode});
        wr(6'h04, 8'h46);
        outs(4'h6);
        wr(6'h02, 8'h71);
        outs(4'h2);
        wr(6'h02, 8'h73);
        outs(4'hE);
        wr(6'h02, 8'h51);
        in1_pin = 1'b0;
        in2_pin = 1'b1;
        outs(4'h1);
        wr(6'h04, 8'h40);
        wr(6'h02, 8'h50);
    endtask
    task automatic olp(input logic [7:0] d, output int n);
        n = 0;
        wr(6'h05, d);
        while (olr !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (olr === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_olp;
        int s, l;
        olp(8'h48, s);
        rchk(6'h05, 8'h08);
        olp(8'h68, l);
        rchk(6'h05, 8'h28);
        cmp("olp_short_ok", 8'h01, {7'h0, s >= 4 && s <= 9});
        cmp("olp_long_ok", 8'h01, {7'h0, l >= s + 3 && l <= 14});
        wr(6'h05, 8'h1D);
        cyc(2);
        cmp("fields", 8'h1D, {3'h0, ola, trip, rdis});
        wr(6'h05, 8'h08);
        cyc(2);
        cmp("fields", 8'h08, {3'h0, ola, trip, rdis});
    endtask
    initial begin
        cyc(16);
        srst = 1'b0;
        t_reset();
        t_lock();
        t_faults();
        t_ocp();
        t_bridge();
        t_olp();
        summarize();
    end
endmodule
`default_nettype wire
